// ### design/sec_checker.sv
// In-line ECC checker: FIFO for read data and the checker top module
`timescale 1ns/1ps

// ==========================================================
// Synchronous FIFO
module sec_fifo #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // sec_fifo

// ==========================================================
// Checker top
module sec_checker import sec_pkg::*; #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [19:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// Host request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [31:0] req_addr,
	input wire logic [63:0] req_data,
	input wire logic [7:0] req_be,
	input wire logic [7:0] req_par,
	// Host read response
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [63:0] rsp_data,
	output logic [7:0] rsp_par,
	// Memory side
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [63:0] mem_wdata,
	output logic [7:0] mem_wcheck,
	input wire logic mem_rvalid,
	input wire logic [63:0] mem_rdata,
	input wire logic [7:0] mem_rcheck,
	// Error report level
	output logic err_report
);
	// ==========================================================
	// Reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// Registers
	logic [7:0] sbe_count;
	logic [7:0] sbe_trigger;
	logic [7:0] err_enable;
	logic [2:0] ecc_config;
	logic det_par_pci;
	logic flag_par;
	logic flag_sbe;
	logic flag_mbe;
	logic [31:0] cap_upper;
	logic [31:0] cap_lower;
	logic [31:0] cap_par;
	sec_state_e state;
	logic [31:0] hold_addr;
	logic [63:0] hold_data;
	logic [7:0] hold_be;

	logic ecc_active;
	logic par_active;
	assign ecc_active = ecc_config[CFG_ECC_BIT]
		&& ecc_config[CFG_BUS64_BIT];
	assign par_active = ecc_config[CFG_PAR_BIT];

	// ==========================================================
	// Read path decode
	logic [7:0] syndrome;
	logic [63:0] fixed_data;
	logic hit_single;
	logic rd_back;
	logic ev_sbe;
	logic ev_mbe;
	logic [7:0] next_count;
	logic ev_report;

	// Recomputed against stored check bits
	assign syndrome = sec_gen(mem_rdata) ^ mem_rcheck;

	always_comb begin
		fixed_data = mem_rdata;
		hit_single = $countones(syndrome) == 1;
		for (int i = 0; i < 64; i++) begin
			if (syndrome == sec_col(i)) begin
				fixed_data[i] = ~mem_rdata[i];
				hit_single = 1'b1;
			end
		end
		if (!ecc_active || syndrome == 8'h00) begin
			fixed_data = mem_rdata;
			hit_single = 1'b0;
		end
	end

	assign rd_back = mem_rvalid
		&& (state == SEC_RD_WAIT || state == SEC_RMW_WAIT);
	assign ev_sbe = rd_back && ecc_active && hit_single;
	// Raw data goes back on a multi-bit hit
	assign ev_mbe = rd_back && ecc_active && syndrome != 8'h00
		&& !hit_single;
	assign next_count = sbe_count + 8'h01;
	// Zero threshold never matches a post-increment count of zero
	assign ev_report = ev_sbe && next_count == sbe_trigger
		&& sbe_trigger != 8'h00;

	// ==========================================================
	// Write-side parity
	logic accept;
	logic ev_par;
	logic partial;
	assign accept = req_valid && req_ready;
	assign ev_par = accept && req_write && par_active
		&& sec_bytepar(req_data) != req_par;
	assign partial = req_be != 8'hff;

	// ==========================================================
	// Response FIFO; one outstanding read keeps room guaranteed
	sec_rsp_s fifo_in;
	sec_rsp_s fifo_out;
	logic fifo_in_ready;
	logic fifo_push;

	assign fifo_push = mem_rvalid && state == SEC_RD_WAIT;
	assign fifo_in.data = fixed_data;
	assign fifo_in.par = sec_bytepar(fixed_data);

	sec_fifo #(
		.WIDTH($bits(sec_rsp_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(rsp_valid),
		.out_ready(rsp_ready),
		.out_data(fifo_out)
	);
	assign rsp_data = fifo_out.data;
	assign rsp_par = fifo_out.par;
	assign req_ready = state == SEC_IDLE && fifo_in_ready;

	// ==========================================================
	// Sequencer and memory commands
	logic [63:0] merged;
	always_comb begin
		merged = fixed_data;
		for (int b = 0; b < 8; b++)
			if (hold_be[b])
				merged[b*8 +: 8] = hold_data[b*8 +: 8];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SEC_IDLE;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 64'h0000_0000_0000_0000;
			mem_wcheck <= 8'h00;
			hold_addr <= 32'h0000_0000;
			hold_data <= 64'h0000_0000_0000_0000;
			hold_be <= 8'h00;
		end else begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			unique case (state)
				SEC_IDLE: begin
					if (accept) begin
						hold_addr <= req_addr;
						hold_data <= req_data;
						hold_be <= req_be;
						mem_req <= 1'b1;
						mem_addr <= req_addr;
						if (!req_write) begin
							state <= SEC_RD_WAIT;
						end else if (partial && ecc_active) begin
							state <= SEC_RMW_WAIT;
						end else begin
							mem_we <= 1'b1;
							mem_wdata <= req_data;
							mem_wcheck <= sec_gen(req_data);
						end
					end
				end
				SEC_RD_WAIT: begin
					// Corrected word is not written back
					if (mem_rvalid)
						state <= SEC_IDLE;
				end
				SEC_RMW_WAIT: begin
					if (mem_rvalid) begin
						state <= SEC_IDLE;
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= hold_addr;
						mem_wdata <= merged;
						mem_wcheck <= sec_gen(merged);
					end
				end
				default: state <= SEC_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Count, threshold and enables
	logic wr_hit;
	assign wr_hit = reg_wr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sbe_count <= COUNT_RESET;
		end else if (ev_sbe) begin
			// Event beats a same-cycle clear: count from cleared state
			if (wr_hit && reg_addr == OFS_SBE_COUNT)
				sbe_count <= 8'h01;
			else
				sbe_count <= next_count;
		end else if (wr_hit && reg_addr == OFS_SBE_COUNT) begin
			sbe_count <= COUNT_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sbe_trigger <= TRIGGER_RESET;
			err_enable <= ENABLE_RESET;
			ecc_config <= CONFIG_RESET;
		end else if (wr_hit) begin
			if (reg_addr == OFS_SBE_TRIGGER)
				sbe_trigger <= reg_wdata[7:0];
			if (reg_addr == OFS_ERR_ENABLE)
				err_enable <= reg_wdata[7:0];
			if (reg_addr == OFS_ECC_CONFIG)
				ecc_config <= reg_wdata[2:0];
		end
	end

	// ==========================================================
	// Sticky flags, write one to clear, set wins
	logic clr_first;
	logic clr_second;
	logic clr_pci;
	assign clr_first = wr_hit && reg_addr == OFS_DETECT_FIRST;
	assign clr_second = wr_hit && reg_addr == OFS_DETECT_SECOND;
	assign clr_pci = wr_hit && reg_addr == OFS_PCI_STATUS;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_par <= 1'b0;
			flag_sbe <= 1'b0;
			flag_mbe <= 1'b0;
			det_par_pci <= 1'b0;
		end else begin
			flag_par <= ev_par
				|| (flag_par && !(clr_first && reg_wdata[DF_PAR_BIT]));
			flag_sbe <= ev_report
				|| (flag_sbe && !(clr_first && reg_wdata[DF_SBE_BIT]));
			flag_mbe <= ev_mbe
				|| (flag_mbe && !(clr_second && reg_wdata[DS_MBE_BIT]));
			det_par_pci <= ev_par || ev_mbe || ev_report
				|| (det_par_pci
				&& !(clr_pci && reg_wdata[PCI_DET_PAR_BIT]));
		end
	end

	// Multi-bit errors ignore the enable register
	assign err_report = flag_mbe
		|| (flag_sbe && err_enable[EN_SBE_BIT])
		|| (flag_par && err_enable[EN_PAR_BIT]);

	// ==========================================================
	// Capture of the faulty transfer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_upper <= CAPTURE_RESET;
			cap_lower <= CAPTURE_RESET;
			cap_par <= CAPTURE_RESET;
		end else if (ev_mbe || ev_report) begin
			cap_upper <= mem_rdata[63:32];
			cap_lower <= mem_rdata[31:0];
			cap_par <= {24'h000000, mem_rcheck};
		end else if (ev_par) begin
			cap_upper <= req_data[63:32];
			cap_lower <= req_data[31:0];
			cap_par <= {24'h000000, req_par};
		end
	end

	// ==========================================================
	// Register read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_PCI_STATUS: reg_rdata <= 32'(det_par_pci)
					<< PCI_DET_PAR_BIT;
				OFS_SBE_COUNT: reg_rdata <= {24'h000000, sbe_count};
				OFS_SBE_TRIGGER: reg_rdata <= {24'h000000, sbe_trigger};
				OFS_ERR_ENABLE: reg_rdata <= {24'h000000, err_enable};
				OFS_DETECT_FIRST: reg_rdata <= (32'(flag_sbe) << DF_SBE_BIT)
					| (32'(flag_par) << DF_PAR_BIT);
				OFS_DETECT_SECOND: reg_rdata <= 32'(flag_mbe)
					<< DS_MBE_BIT;
				OFS_ECC_CONFIG: reg_rdata <= {29'h00000000, ecc_config};
				OFS_CAP_UPPER: reg_rdata <= cap_upper;
				OFS_CAP_LOWER: reg_rdata <= cap_lower;
				OFS_CAP_PARITY: reg_rdata <= cap_par;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Checks
	chk_mbe_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		ev_mbe |=> flag_mbe && err_report)
		else $error("multi-bit error not flagged");
	chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
		ev_sbe && !wr_hit |=> sbe_count == $past(sbe_count) + 8'h01)
		else $error("count did not step by one");
	chk_silent_fix: assert property (@(posedge clk) disable iff (!rst_n)
		ev_sbe && next_count != sbe_trigger && !flag_sbe
		|=> !flag_sbe)
		else $error("report raised without threshold match");
	chk_zero_trigger: assert property (@(posedge clk) disable iff (!rst_n)
		sbe_trigger == 8'h00 && !flag_sbe |=> !flag_sbe)
		else $error("zero threshold still reported");
	chk_count_clear: assert property (@(posedge clk) disable iff (!rst_n)
		wr_hit && reg_addr == OFS_SBE_COUNT && !ev_sbe
		|=> sbe_count == 8'h00)
		else $error("count not cleared by write");
	chk_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
		fifo_push |=> rsp_valid)
		else $error("read data late");
	chk_write_check: assert property (@(posedge clk) disable iff (!rst_n)
		mem_we |-> mem_req && mem_wcheck == sec_gen(mem_wdata))
		else $error("stored check bits wrong");
	chk_rmw_order: assert property (@(posedge clk) disable iff (!rst_n)
		accept && req_write && partial && ecc_active
		|=> mem_req && !mem_we ##1 state == SEC_RMW_WAIT)
		else $error("partial write not read first");
	chk_capture_load: assert property (@(posedge clk) disable iff (!rst_n)
		ev_mbe |=> cap_lower == $past(mem_rdata[31:0]))
		else $error("capture not loaded");
	chk_clean_pass: assert property (@(posedge clk) disable iff (!rst_n)
		fifo_push && syndrome == 8'h00 |-> fifo_in.data == mem_rdata)
		else $error("clean word altered");
endmodule // sec_checker

// ### design/sec_pkg.sv
// Shared constants, types and code matrix for the in-line ECC checker
package sec_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [19:0] OFS_PCI_STATUS = 20'h00006;
	localparam logic [19:0] OFS_SBE_COUNT = 20'h000b8;
	localparam logic [19:0] OFS_SBE_TRIGGER = 20'h000b9;
	localparam logic [19:0] OFS_ERR_ENABLE = 20'h000c0;
	localparam logic [19:0] OFS_DETECT_FIRST = 20'h000c1;
	localparam logic [19:0] OFS_DETECT_SECOND = 20'h000c5;
	localparam logic [19:0] OFS_ECC_CONFIG = 20'h000f0;
	localparam logic [19:0] OFS_CAP_UPPER = 20'hff00c;
	localparam logic [19:0] OFS_CAP_LOWER = 20'hff010;
	localparam logic [19:0] OFS_CAP_PARITY = 20'hff014;
	// ==========================================================
	// Field positions
	localparam int PCI_DET_PAR_BIT = 15;
	localparam int DF_PAR_BIT = 0;
	localparam int DF_SBE_BIT = 2;
	localparam int DS_MBE_BIT = 3;
	localparam int EN_PAR_BIT = 0;
	localparam int EN_SBE_BIT = 2;
	localparam int CFG_ECC_BIT = 0;
	localparam int CFG_PAR_BIT = 1;
	localparam int CFG_BUS64_BIT = 2;
	// ==========================================================
	// Reset values
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] TRIGGER_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [2:0] CONFIG_RESET = 3'h4;
	localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SEC_IDLE = 2'b00,
		SEC_RD_WAIT = 2'b01,
		SEC_RMW_WAIT = 2'b10
	} sec_state_e;

	typedef struct packed {
		logic [63:0] data;
		logic [7:0] par;
	} sec_rsp_s;

	// Column of the check matrix for data bit i: odd weight, weight 3 first
	function automatic logic [7:0] sec_col(input int i);
		int n;
		logic [7:0] r;
		n = 0;
		r = 8'h00;
		for (int w = 3; w <= 5; w += 2) begin
			for (int v = 0; v < 256; v++) begin
				if ($countones(8'(v)) == w) begin
					if (n == i)
						r = 8'(v);
					n++;
				end
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] sec_gen(input logic [63:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 64; i++)
			if (d[i])
				c = c ^ sec_col(i);
		return c;
	endfunction

	function automatic logic [7:0] sec_bytepar(input logic [63:0] d);
		logic [7:0] p;
		p = 8'h00;
		for (int b = 0; b < 8; b++)
			p[b] = ^d[b*8 +: 8];
		return p;
	endfunction
endpackage

// ### sim/sec_mem_model.sv
// Behavioural memory array with a check-bit lane for the checker bench
`timescale 1ns/1ps

module sec_mem_model (
	// Clock
	input wire logic clk,
	// Command from the checker
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	input wire logic [7:0] mem_wcheck,
	// Read return
	output logic mem_rvalid,
	output logic [63:0] mem_rdata,
	output logic [7:0] mem_rcheck,
	// Test control
	input wire logic [3:0] lat,
	input wire logic [71:0] flip,
	output int n_wr
);
	logic [71:0] arr [16];
	logic [3:0] cnt;
	logic [3:0] radr;

	initial begin
		mem_rvalid = 1'b0;
		{mem_rcheck, mem_rdata} = 72'h0;
		cnt = 4'h0;
		radr = 4'h0;
		n_wr = 0;
	end

	// ==========================================================
	// Answer after lat cycles; flip inverts the selected bits on the way back
	always @(posedge clk) begin
		mem_rvalid <= 1'b0;
		// Released lines toggle so stale data never looks valid
		{mem_rcheck, mem_rdata} <= ~{mem_rcheck, mem_rdata};
		if (cnt == 4'h1) begin
			mem_rvalid <= 1'b1;
			{mem_rcheck, mem_rdata} <= arr[radr] ^ flip;
		end
		if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (mem_req && mem_we) begin
			arr[mem_addr[3:0]] <= {mem_wcheck, mem_wdata};
			n_wr <= n_wr + 1;
		end else if (mem_req) begin
			radr <= mem_addr[3:0];
			cnt <= lat;
		end
	end
endmodule // sec_mem_model

// ### sim/sec_checker_tb.sv
// Self-checking bench for the in-line ECC checker
`timescale 1ns/1ps

module sec_checker_tb import sec_pkg::*;;
	logic clk, nrst, reg_wr, reg_rd, req_valid, req_ready, req_write;
	logic [19:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, req_addr, mem_addr;
	logic [63:0] req_data, rsp_data, mem_wdata, mem_rdata;
	logic [7:0] req_be, req_par, rsp_par, mem_wcheck, mem_rcheck;
	logic rsp_valid, rsp_ready, mem_req, mem_we, mem_rvalid, err_report;
	logic [3:0] lat;
	logic [71:0] flip;
	int n_wr, n_fail, checks;

	sec_checker #(.FIFO_DEPTH(32)) u_dut (.clk(clk), .nrst(nrst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_addr(req_addr), .req_data(req_data),
		.req_be(req_be), .req_par(req_par), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_par(rsp_par),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wcheck(mem_wcheck),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.mem_rcheck(mem_rcheck), .err_report(err_report));

	sec_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wcheck(mem_wcheck),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.mem_rcheck(mem_rcheck), .lat(lat), .flip(flip), .n_wr(n_wr));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Reference code, written apart from the design's own functions
	function automatic logic [7:0] ck(input logic [63:0] d);
		logic [7:0] c;
		int n;
		c = 8'h00;
		n = 0;
		for (int w = 3; w <= 5; w += 2)
			for (int v = 0; v < 256; v++)
				if ($countones(v[7:0]) == w) begin
					if (n < 64 && d[n])
						c ^= v[7:0];
					n++;
				end
		return c;
	endfunction

	function automatic logic [7:0] bp(input logic [63:0] d);
		for (int b = 0; b < 8; b++)
			bp[b] = ^d[b*8 +: 8];
	endfunction

	function automatic logic [63:0] dv(input int a);
		return 64'h0123_4567_89ab_cdef ^ 64'(a);
	endfunction

	// ==========================================================
	// Bus tasks and checking
	task automatic close_out();
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic hang();
		n_fail++;
		close_out();
	endtask

	task automatic chk(input string n, input logic [71:0] s,
		input logic [71:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic reg_w(input logic [19:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_chk(input logic [19:0] a, input logic [31:0] e,
		input string n);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(n, 72'(reg_rdata), 72'(e));
	endtask

	task automatic host(input logic wr, input logic [31:0] a,
		input logic [63:0] d, input logic [7:0] be, input logic [7:0] par);
		logic ok;
		ok = 1'b0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_data <= d;
		req_be <= be;
		req_par <= par;
		for (int i = 0; i < 200 && !ok; i++) begin
			#1 ok = (req_ready === 1'b1);
			@(posedge clk);
		end
		if (!ok)
			hang();
		req_valid <= 1'b0;
	endtask

	task automatic rd(input int a, output logic [63:0] d, output logic [7:0] p);
		int i;
		host(1'b0, 32'(a), 64'h0, 8'hff, 8'h00);
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			#1;
			if (mem_rvalid === 1'b1)
				break;
		end
		if (i == 50)
			hang();
		@(posedge clk);
		#1 chk("rsp_valid", 72'(rsp_valid), 72'h1);
		d = rsp_data;
		p = rsp_par;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_init();
		reg_chk(OFS_ECC_CONFIG, 32'(CONFIG_RESET), "config");
		reg_chk(OFS_SBE_COUNT, 32'h0, "count_reset");
		reg_chk(20'h00044, 32'h0, "unmapped");
		reg_w(OFS_ECC_CONFIG, 32'h7);
		for (int a = 0; a < 16; a++) begin
			host(1'b1, 32'(a), dv(a), 8'hff, bp(dv(a)));
			#1 chk("wcheck", 72'({mem_we, mem_wcheck}),
				72'({1'b1, ck(dv(a))}));
		end
	endtask

	task automatic t_clean();
		logic [63:0] d;
		logic [7:0] p;
		for (int l = 1; l <= 5; l += 4) begin
			lat <= 4'(l);
			rd(l, d, p);
			chk("clean", 72'(d), 72'(dv(l)));
			chk("rsp_par", 72'(p), 72'(bp(dv(l))));
		end
		lat <= 4'h1;
	endtask

	task automatic t_sbe();
		logic [63:0] d;
		logic [7:0] p;
		int w;
		w = n_wr;
		reg_w(OFS_SBE_TRIGGER, 32'h2);
		reg_w(OFS_ERR_ENABLE, 32'h5);
		for (int k = 1; k <= 3; k++) begin
			// Third pass hits a check bit, not a data bit
			flip <= 72'h1 << ((k == 3) ? 70 : k * 54 - 45);
			rd(1, d, p);
			chk("corrected", 72'(d), 72'(dv(1)));
			reg_chk(OFS_SBE_COUNT, 32'(k), "count");
			chk("sbe_report", 72'(err_report), 72'(k >= 2));
		end
		chk("no_writeback", 72'(n_wr - w), 72'h0);
		reg_chk(OFS_DETECT_FIRST, 32'h4, "sbe_flag");
		reg_w(OFS_DETECT_FIRST, 32'h4);
		reg_w(OFS_SBE_COUNT, 32'h55);
		reg_chk(OFS_SBE_COUNT, 32'h0, "count_clear");
		reg_w(OFS_SBE_TRIGGER, 32'h0);
		flip <= 72'h1;
		for (int j = 1; j <= 256; j++) begin
			rd(1, d, p);
			if (j == 1)
				reg_chk(OFS_SBE_COUNT, 32'h1, "count_one");
		end
		// Last pass wraps the count to zero, equal to a zero threshold
		reg_chk(OFS_SBE_COUNT, 32'h0, "count_wrap");
		chk("zero_trigger", 72'(err_report), 72'h0);
	endtask

	task automatic t_mbe();
		logic [63:0] d, e;
		logic [7:0] p;
		logic [71:0] f;
		reg_w(OFS_ERR_ENABLE, 32'h0);
		for (int k = 0; k < 2; k++) begin
			// One nibble pair, then two bits far apart
			f = k ? 72'h100_0000_0020 : 72'h3;
			e = dv(4) ^ f[63:0];
			flip <= f;
			rd(4, d, p);
			chk("raw", 72'(d), 72'(e));
			reg_chk(OFS_DETECT_SECOND, 32'h8, "mbe_flag");
			chk("mbe_report", 72'(err_report), 72'h1);
			reg_chk(OFS_CAP_UPPER, e[63:32], "cap_upper");
			reg_chk(OFS_CAP_LOWER, e[31:0], "cap_lower");
			reg_w(OFS_DETECT_SECOND, 32'h8);
		end
	endtask

	task automatic t_mode();
		logic [63:0] d;
		logic [7:0] p;
		for (int k = 0; k < 2; k++) begin
			// Narrow bus first, then correction switched off
			reg_w(OFS_ECC_CONFIG, k ? 32'h6 : 32'h3);
			flip <= 72'h10;
			rd(6, d, p);
			chk("unchecked", 72'(d), 72'(dv(6) ^ 64'h10));
		end
		flip <= 72'h0;
		reg_w(OFS_ECC_CONFIG, 32'h7);
	endtask

	task automatic t_rmw();
		logic [63:0] m;
		int w;
		w = n_wr;
		m = (dv(2) & ~64'hff) | 64'ha5;
		host(1'b1, 32'h2, 64'ha5, 8'h01, bp(64'ha5));
		#1 chk("rmw_read", 72'({mem_req, mem_we}), 72'h2);
		for (int i = 0; i < 50 && n_wr == w; i++)
			@(posedge clk);
		if (n_wr == w)
			hang();
		#1 chk("rmw_word", u_mem.arr[2], {ck(m), m});
	endtask

	task automatic t_par();
		reg_w(OFS_ERR_ENABLE, 32'h1);
		// Earlier memory errors left the status flag set
		reg_w(OFS_PCI_STATUS, 32'h8000);
		for (int k = 0; k < 2; k++) begin
			reg_w(OFS_ECC_CONFIG, k ? 32'h5 : 32'h7);
			host(1'b1, 32'h3, dv(3), 8'hff, bp(dv(3)) ^ 8'h01);
			#1 chk("par_write", 72'(mem_req & mem_we), 72'h1);
			reg_chk(OFS_DETECT_FIRST, k ? 32'h0 : 32'h1, "par_flag");
			chk("par_report", 72'(err_report), 72'(k == 0));
			reg_chk(OFS_PCI_STATUS, k ? 32'h0 : 32'h8000, "pci_flag");
			reg_w(OFS_DETECT_FIRST, 32'h1);
			reg_w(OFS_PCI_STATUS, 32'h8000);
		end
		reg_chk(OFS_CAP_LOWER, 32'h89ab_cdec, "cap_par");
		reg_chk(OFS_CAP_PARITY, 32'(bp(dv(3)) ^ 8'h01), "cap_parity");
		reg_w(OFS_ECC_CONFIG, 32'h7);
	endtask

	task automatic t_fifo();
		int n;
		rsp_ready <= 1'b0;
		for (int k = 0; k < 32; k++)
			host(1'b0, 32'(k % 16), 64'h0, 8'hff, 8'h00);
		for (n = 0; n < 50 && mem_rvalid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 50)
			hang();
		repeat (2) @(posedge clk);
		#1 chk("full_refuse", 72'(req_ready), 72'h0);
		rsp_ready <= 1'b1;
		n = 0;
		for (int i = 0; i < 100 && rsp_valid === 1'b1; i++) begin
			@(posedge clk);
			#1 n++;
		end
		chk("drained", 72'(n), 72'h20);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 20'h0;
		reg_wdata = 32'h0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 32'h0;
		req_data = 64'h0;
		req_be = 8'h0;
		req_par = 8'h0;
		rsp_ready = 1'b1;
		lat = 4'h1;
		flip = 72'h0;
		n_fail = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		// Synchroniser needs two edges before requests are safe
		repeat (3) @(posedge clk);
		t_init();
		t_clean();
		t_sbe();
		t_mbe();
		t_mode();
		t_rmw();
		t_par();
		t_fifo();
		close_out();
	end
endmodule // sec_checker_tb
